// [rtl/eiq_pkg.sv]
// package: offsets, field positions, reset values and timing counts for the error interrupt block
package eiq_pkg;
   // register indices; each register owns one aligned word at four times its index
   localparam logic [11:0] EIQ_MASK_OFFSET = 12'h03A;
   localparam logic [11:0] EIQ_REPORT_OFFSET = 12'h03C;
   // ahb byte addresses, register value in bits 15:0 of its word
   localparam logic [11:0] EIQ_MASK_WORD = 12'(EIQ_MASK_OFFSET * 4);
   localparam logic [11:0] EIQ_REPORT_WORD = 12'(EIQ_REPORT_OFFSET * 4);
   localparam int EIQ_MASK_LANE = 0;
   // mask fields
   localparam int EIQ_EN_CMD_TIMEOUT = 0;
   localparam int EIQ_EN_CMD_CRC = 1;
   localparam int EIQ_EN_CMD_ENDBIT = 2;
   localparam int EIQ_EN_CMD_INDEX = 3;
   localparam int EIQ_EN_DAT_TIMEOUT = 4;
   localparam int EIQ_EN_DAT_CRC = 5;
   localparam int EIQ_EN_DAT_ENDBIT = 6;
   localparam int EIQ_EN_CUR_LIMIT = 7;
   localparam int EIQ_EN_STOP_CMD = 8;
   localparam int EIQ_EN_DESC_DMA = 9;
   localparam int EIQ_EN_VENDOR_LO = 12;
   localparam logic [15:0] EIQ_MASK_WRITABLE = 16'hF3FF;
   localparam logic [15:0] EIQ_MASK_RESET = 16'h0000;
   // report fields
   localparam int EIQ_RP_NOT_EXEC = 0;
   localparam int EIQ_RP_TIMEOUT = 1;
   localparam int EIQ_RP_CRC = 2;
   localparam int EIQ_RP_ENDBIT = 3;
   localparam int EIQ_RP_INDEX = 4;
   localparam int EIQ_RP_NOT_ISSUED = 7;
   localparam logic [15:0] EIQ_REPORT_RESET = 16'h0000;
   // response timeout in card clock cycles
   localparam int EIQ_RESP_TIMEOUT_CYCLES = 64;
   localparam int EIQ_TCNT_W = 7;
   localparam logic [1:0] EIQ_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] EIQ_HSIZE_WORD = 3'h2;
   typedef enum logic [1:0] {
      EIQ_IDLE = 2'b00,
      EIQ_WAIT = 2'b01,
      EIQ_DONE = 2'b10
   } eiq_state_t;
endpackage : eiq_pkg

// [rtl/eiq_irq_combine.sv]
// per-source gating of error status onto one registered interrupt line
`timescale 1ns/1ps
module eiq_irq_combine #(
   parameter int WIDTH = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [WIDTH-1:0] status,
   input wire logic [WIDTH-1:0] enable,
   output logic irq
);
   if (WIDTH < 1) begin : g_bad_width
      $error("width must be at least one");
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & enable);
      end
   end
endmodule : eiq_irq_combine

// [rtl/eiq_resp_timer.sv]
// counts card clock ticks after the stop command end bit, flags missing response start
`timescale 1ns/1ps
module eiq_resp_timer #(
   parameter int LIMIT = eiq_pkg::EIQ_RESP_TIMEOUT_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic stop,
   input wire logic tick,
   output logic expired
);
   import eiq_pkg::*;
   logic [EIQ_TCNT_W-1:0] count;
   logic running;
   if (LIMIT < 1 || LIMIT >= (1 << EIQ_TCNT_W)) begin : g_bad_limit
      $error("timeout limit out of range");
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= '0;
         running <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (start) begin
            count <= '0;
            running <= 1'b1;
         end else if (stop) begin
            running <= 1'b0;
         end else if (running && tick) begin
            if (count == EIQ_TCNT_W'(LIMIT - 1)) begin
               running <= 1'b0;
               expired <= 1'b1;
            end
            count <= count + EIQ_TCNT_W'(1);
         end
      end
   end
endmodule : eiq_resp_timer

// [rtl/eiq_error_irq.sv]
// error interrupt mask, stop-command error report and the shared interrupt line
//
// Function
// - all selected error sources drive one common interrupt output
// - enable bit 1 lets its status raise the interrupt, 0 masks it
// - bits 15-12 are a read/write mask for vendor error sources
// - bit 9 descriptor dma, bit 8 stop command, bit 7 current limit
// - bit 6 data end bit, bit 5 data crc, bit 4 data timeout
// - bit 3 index, bit 2 end bit, bit 1 crc, bit 0 command timeout
// - report content is meaningful only while the summary error bit is set
// - bit 7 set when a command without data was held by a response error
// - bit 4 set when the response index differs from the sent command
// - bit 3 set when the response end bit arrives as zero
// - bit 2 set when the response crc check fails
// - bit 1 set when no response start within 64 card clocks
// - when timeout is set, index, end-bit and crc bits carry nothing
// - bit 0 reports the stop command was not executed
// - bit 0 set if a prior error blocks issue, cleared when issued
// - response error bits evaluated at response end bit, set or cleared
// - summary error fires on bits 0 to 4; bit 7 alone never does
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module eiq_error_irq #(
   parameter int TIMEOUT_CYCLES = eiq_pkg::EIQ_RESP_TIMEOUT_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [15:0] err_status_in,
   input wire logic stop_cmd_request,
   input wire logic prior_cmd_error,
   input wire logic stop_cmd_end_bit_sent,
   input wire logic card_clk_tick,
   input wire logic resp_start_seen,
   input wire logic resp_end_bit_strobe,
   input wire logic resp_index_mismatch,
   input wire logic resp_end_bit_value,
   input wire logic resp_crc_fail,
   input wire logic command_without_data_pending,
   output logic err_irq,
   output logic stop_cmd_error,
   output logic stop_cmd_issued
);
   import eiq_pkg::*;

   // ------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------
   // the timer counts in a fixed width, so the limit must fit it
   if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << EIQ_TCNT_W)) begin : g_bad_timeout
      $error("timeout limit does not fit the response timer");
   end

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   logic [15:0] error_irq_line_mask;
   logic [15:0] stop_command_error_report;
   logic dp_write;
   logic [11:0] dp_addr;
   logic read_mask_sel;
   logic read_report_sel;
   logic timeout_hit;
   eiq_state_t state;
   eiq_state_t next_state;
   logic [15:0] status_vec;
   logic [15:0] wr_lane;

   function automatic logic word_hit(input logic [11:0] a, input logic [11:0] w);
      word_hit = (a[11:2] == w[11:2]);
   endfunction : word_hit

   wire logic take = hsel && hready && htrans == EIQ_HTRANS_NONSEQ;
   assign wr_lane = hwdata[EIQ_MASK_LANE +: 16];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_addr <= 12'h000;
      end else begin
         dp_write <= take && hwrite && hsize == EIQ_HSIZE_WORD;
         if (take) begin
            dp_addr <= haddr;
         end
      end
   end

   // zero-wait slave, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign read_mask_sel = take && !hwrite && word_hit(haddr, EIQ_MASK_WORD);
   assign read_report_sel = take && !hwrite && word_hit(haddr, EIQ_REPORT_WORD);

   // read data registered in the address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (read_mask_sel) begin
         hrdata <= {16'h0000, error_irq_line_mask};
      end else if (read_report_sel) begin
         hrdata <= {16'h0000, stop_command_error_report};
      end else if (take) begin
         hrdata <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // mask register
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         error_irq_line_mask <= EIQ_MASK_RESET;
      end else if (dp_write && word_hit(dp_addr, EIQ_MASK_WORD)) begin
         // reserved bits 11-10 stay zero
         error_irq_line_mask <= wr_lane & EIQ_MASK_WRITABLE;
      end
   end

   // ------------------------------------------------------------
   // stop-command sequencing
   // ------------------------------------------------------------
   eiq_resp_timer #(
      .LIMIT(TIMEOUT_CYCLES)
   ) u_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(stop_cmd_end_bit_sent),
      .stop(resp_start_seen),
      .tick(card_clk_tick),
      .expired(timeout_hit)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= EIQ_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         EIQ_IDLE: begin
            if (stop_cmd_request && !prior_cmd_error) next_state = EIQ_WAIT;
         end
         EIQ_WAIT: begin
            if (resp_end_bit_strobe || timeout_hit) next_state = EIQ_DONE;
         end
         EIQ_DONE: begin
            next_state = EIQ_IDLE;
         end
         default: begin
            next_state = EIQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_cmd_issued <= 1'b0;
      end else begin
         stop_cmd_issued <= state == EIQ_IDLE && stop_cmd_request && !prior_cmd_error;
      end
   end

   // ------------------------------------------------------------
   // report register
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_command_error_report <= EIQ_REPORT_RESET;
      end else begin
         if (state == EIQ_IDLE && stop_cmd_request) begin
            stop_command_error_report[EIQ_RP_NOT_EXEC] <= prior_cmd_error;
         end
         if (state == EIQ_WAIT && resp_end_bit_strobe) begin
            stop_command_error_report[EIQ_RP_TIMEOUT] <= 1'b0;
            stop_command_error_report[EIQ_RP_INDEX] <= resp_index_mismatch;
            stop_command_error_report[EIQ_RP_ENDBIT] <= !resp_end_bit_value;
            stop_command_error_report[EIQ_RP_CRC] <= resp_crc_fail;
         end else if (state == EIQ_WAIT && timeout_hit) begin
            // other response bits have no meaning here, forced clear
            stop_command_error_report[EIQ_RP_TIMEOUT] <= 1'b1;
            stop_command_error_report[4:2] <= 3'h0;
         end
         // sampled continuously so a read sees the current pending command
         stop_command_error_report[EIQ_RP_NOT_ISSUED] <= command_without_data_pending
            && |stop_command_error_report[EIQ_RP_INDEX:EIQ_RP_TIMEOUT];
         stop_command_error_report[15:8] <= 8'h00;
         stop_command_error_report[6:5] <= 2'h0;
      end
   end

   // bit 7 deliberately excluded from the summary
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_cmd_error <= 1'b0;
      end else begin
         stop_cmd_error <= |stop_command_error_report[EIQ_RP_INDEX:EIQ_RP_NOT_EXEC];
      end
   end

   // ------------------------------------------------------------
   // interrupt line
   // ------------------------------------------------------------
   // bit 8 carries the internal stop-command summary instead of the pin
   for (genvar i = 0; i < 16; i++) begin : g_status
      if (i == EIQ_EN_STOP_CMD) begin : g_internal
         assign status_vec[i] = stop_cmd_error;
      end else begin : g_pin
         assign status_vec[i] = err_status_in[i];
      end
   end

   eiq_irq_combine #(
      .WIDTH(16)
   ) u_irq (
      .hclk(hclk),
      .hresetn(hresetn),
      .status(status_vec),
      .enable(error_irq_line_mask),
      .irq(err_irq)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_irq_follows_mask: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 err_irq == $past(|(status_vec & error_irq_line_mask)))
      else $error("interrupt not the masked or of status");
   a_reserved_mask_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      error_irq_line_mask[11:10] == 2'h0)
      else $error("reserved mask bits set");
   a_report_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 stop_command_error_report[15:8] == 8'h00 && stop_command_error_report[6:5] == 2'h0)
      else $error("reserved report bits set");
   a_timeout_sets_bit: assert property (@(posedge hclk) disable iff (!hresetn)
      state == EIQ_WAIT && timeout_hit && !resp_end_bit_strobe |=>
      stop_command_error_report[EIQ_RP_TIMEOUT] && stop_command_error_report[4:2] == 3'h0)
      else $error("timeout not reported");
   a_endbit_zero_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      state == EIQ_WAIT && resp_end_bit_strobe |=>
      stop_command_error_report[EIQ_RP_ENDBIT] == !$past(resp_end_bit_value)
      && stop_command_error_report[EIQ_RP_CRC] == $past(resp_crc_fail)
      && stop_command_error_report[EIQ_RP_INDEX] == $past(resp_index_mismatch))
      else $error("response error bits wrong");
   a_not_exec_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      state == EIQ_IDLE && stop_cmd_request |=>
      stop_command_error_report[EIQ_RP_NOT_EXEC] == $past(prior_cmd_error))
      else $error("not executed bit wrong");
   a_summary_excludes: assert property (@(posedge hclk) disable iff (!hresetn)
      stop_command_error_report[4:0] == 5'h00 |=> !stop_cmd_error)
      else $error("summary raised without error bits");
   a_issue_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
      stop_cmd_issued |-> !$past(prior_cmd_error) ##1 !stop_cmd_issued)
      else $error("issue with prior error");
   a_not_issued: assert property (@(posedge hclk) disable iff (!hresetn)
      stop_command_error_report[EIQ_RP_NOT_ISSUED] |-> $past(command_without_data_pending))
      else $error("not issued bit without pending command");

   // bus and mask
   a_mask_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
      dp_write && word_hit(dp_addr, EIQ_MASK_WORD) |=> error_irq_line_mask == ($past(wr_lane) & EIQ_MASK_WRITABLE))
      else $error("mask write lost");
   a_mask_holds: assert property (@(posedge hclk) disable iff (!hresetn)
      !(dp_write && word_hit(dp_addr, EIQ_MASK_WORD)) |=> $stable(error_irq_line_mask))
      else $error("mask changed without a write");
   a_read_mask_data: assert property (@(posedge hclk) disable iff (!hresetn)
      read_mask_sel |=> hrdata == {16'h0000, $past(error_irq_line_mask)})
      else $error("mask read data wrong");
   a_read_report_data: assert property (@(posedge hclk) disable iff (!hresetn)
      read_report_sel |=> hrdata == {16'h0000, $past(stop_command_error_report)})
      else $error("report read data wrong");
   a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !hwrite && !word_hit(haddr, EIQ_MASK_WORD) && !word_hit(haddr, EIQ_REPORT_WORD)
      |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   // stop-command report
   a_report_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      state != EIQ_WAIT |=> $stable(stop_command_error_report[EIQ_RP_INDEX:EIQ_RP_TIMEOUT]))
      else $error("response bits changed outside evaluation");
   a_endbit_clears_timeout: assert property (@(posedge hclk) disable iff (!hresetn)
      state == EIQ_WAIT && resp_end_bit_strobe |=> !stop_command_error_report[EIQ_RP_TIMEOUT])
      else $error("timeout bit left set by a response");
   a_timeout_clears_rest: assert property (@(posedge hclk) disable iff (!hresetn)
      stop_command_error_report[EIQ_RP_TIMEOUT] |-> stop_command_error_report[4:2] == 3'h0)
      else $error("response bits set beside timeout");
   a_bit0_holds: assert property (@(posedge hclk) disable iff (!hresetn)
      !(state == EIQ_IDLE && stop_cmd_request) |=> $stable(stop_command_error_report[EIQ_RP_NOT_EXEC]))
      else $error("not executed bit changed without a request");
   a_not_exec_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      stop_command_error_report[EIQ_RP_NOT_EXEC] |-> state == EIQ_IDLE)
      else $error("stop command running while reported not executed");
   a_no_issue_prior: assert property (@(posedge hclk) disable iff (!hresetn)
      state == EIQ_IDLE && stop_cmd_request && prior_cmd_error |=> !stop_cmd_issued)
      else $error("stop command issued despite prior error");
   a_issue_when_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      state == EIQ_IDLE && stop_cmd_request && !prior_cmd_error |=> stop_cmd_issued && state == EIQ_WAIT)
      else $error("stop command not issued");
   a_request_ignored_busy: assert property (@(posedge hclk) disable iff (!hresetn)
      state != EIQ_IDLE |=> !stop_cmd_issued)
      else $error("stop command issued while busy");
   a_wait_leaves: assert property (@(posedge hclk) disable iff (!hresetn)
      state == EIQ_WAIT && (resp_end_bit_strobe || timeout_hit) |=> state == EIQ_DONE ##1 state == EIQ_IDLE)
      else $error("sequencer did not finish the exchange");
   a_not_issued_sets: assert property (@(posedge hclk) disable iff (!hresetn)
      command_without_data_pending && |stop_command_error_report[4:1] |=> stop_command_error_report[7])
      else $error("not issued bit missing");
   a_not_issued_clears: assert property (@(posedge hclk) disable iff (!hresetn)
      !(command_without_data_pending && |stop_command_error_report[4:1]) |=> !stop_command_error_report[7])
      else $error("not issued bit stale");
   a_summary_raises: assert property (@(posedge hclk) disable iff (!hresetn)
      |stop_command_error_report[4:0] |=> stop_cmd_error)
      else $error("summary missing for an error bit");

   // interrupt line
   a_irq_masked_off: assert property (@(posedge hclk) disable iff (!hresetn)
      (status_vec & error_irq_line_mask) == 16'h0000 |=> !err_irq)
      else $error("interrupt raised by masked sources");
   for (genvar i = 0; i < 16; i++) begin : g_source_check
      a_source_raises: assert property (@(posedge hclk) disable iff (!hresetn)
         status_vec[i] && error_irq_line_mask[i] |=> err_irq)
         else $error("enabled source did not raise the interrupt");
   end
endmodule : eiq_error_irq

// [test/eiq_card_model.sv]
// memory card model answering the stop command on the command line
`timescale 1ns/1ps
module eiq_card_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic end_bit_sent,
   input wire logic cfg_respond,
   input wire logic cfg_slow,
   input wire logic cfg_index_bad,
   input wire logic cfg_endbit_zero,
   input wire logic cfg_crc_bad,
   output logic card_clk_tick,
   output logic resp_start_seen,
   output logic resp_end_bit_strobe,
   output logic resp_index_mismatch,
   output logic resp_end_bit_value,
   output logic resp_crc_fail
);
   logic strobe_on;
   logic noise;
   // qualifiers carry junk outside the strobe so a stale value cannot pass
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) noise <= 1'b0;
      else noise <= ~noise;
   end
   assign resp_end_bit_strobe = strobe_on;
   assign resp_index_mismatch = strobe_on ? cfg_index_bad : noise;
   assign resp_end_bit_value = strobe_on ? ~cfg_endbit_zero : ~noise;
   assign resp_crc_fail = strobe_on ? cfg_crc_bad : noise;
   task automatic tick_n(input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge hclk);
         card_clk_tick <= 1'b1;
         @(posedge hclk);
         card_clk_tick <= 1'b0;
      end
   endtask : tick_n
   initial begin
      card_clk_tick = 1'b0;
      resp_start_seen = 1'b0;
      strobe_on = 1'b0;
   end
   // card clock only runs inside an exchange
   always begin
      @(posedge hclk);
      if (hresetn && end_bit_sent) begin
         if (cfg_respond) begin
            tick_n(cfg_slow ? 3 : 1);
            @(posedge hclk);
            resp_start_seen <= 1'b1;
            @(posedge hclk);
            resp_start_seen <= 1'b0;
            tick_n(2);
            @(posedge hclk);
            strobe_on <= 1'b1;
            @(posedge hclk);
            strobe_on <= 1'b0;
         end else begin
            tick_n(8);
         end
      end
   end
endmodule : eiq_card_model

// [test/tb_top.sv]
// testbench for the error interrupt mask and stop-command error report
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
   import eiq_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
   logic [11:0] haddr = 0;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 0;
   logic [31:0] hwdata = 0, hrdata, rd;
   logic hreadyout, hresp, err_irq, stop_cmd_error, stop_cmd_issued;
   logic [15:0] err_status_in = 0;
   logic req = 0, prior = 0, ebs = 0, pend = 0, c_resp = 0, c_slow = 0, c_idx = 0, c_eb = 0, c_crc = 0;
   logic tick, rss, rstb, rim, rebv, rcf;
   int n_errors = 0, comparisons = 0;
   always #12.5 hclk = ~hclk;
   assign hready = hreadyout;
   eiq_error_irq #(.TIMEOUT_CYCLES(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .err_status_in(err_status_in), .stop_cmd_request(req),
      .prior_cmd_error(prior), .stop_cmd_end_bit_sent(ebs), .card_clk_tick(tick), .resp_start_seen(rss),
      .resp_end_bit_strobe(rstb), .resp_index_mismatch(rim), .resp_end_bit_value(rebv), .resp_crc_fail(rcf),
      .command_without_data_pending(pend), .err_irq(err_irq), .stop_cmd_error(stop_cmd_error),
      .stop_cmd_issued(stop_cmd_issued));
   eiq_card_model card (.hclk(hclk), .hresetn(hresetn), .end_bit_sent(ebs), .cfg_respond(c_resp),
      .cfg_slow(c_slow), .cfg_index_bad(c_idx), .cfg_endbit_zero(c_eb), .cfg_crc_bad(c_crc),
      .card_clk_tick(tick), .resp_start_seen(rss), .resp_end_bit_strobe(rstb), .resp_index_mismatch(rim),
      .resp_end_bit_value(rebv), .resp_crc_fail(rcf));
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task automatic settle(input int n);
      repeat (n) @(posedge hclk);
      @(negedge hclk);
   endtask : settle
   // hready is looked at half a cycle early, which equals its value at the edge
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge hclk);
      hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= EIQ_HTRANS_NONSEQ; hsize <= EIQ_HSIZE_WORD;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin @(negedge hclk); n++; end while (hready !== 1'b1 && n < 20);
         if (n >= 20) begin n_errors++; print_verdict(); end
         rd = hrdata;
         @(posedge hclk);
         if (p == 0) begin hsel <= 1'b0; htrans <= 2'h0; hwdata <= d; end
      end
   endtask : bus
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_regs;
      bus(EIQ_MASK_WORD, 1'b0, 32'h0); `CHK(rd, 32'(EIQ_MASK_RESET))
      `CHK({hreadyout, hresp, err_irq, stop_cmd_error}, 4'h8)
      bus(EIQ_MASK_WORD, 1'b1, 32'hFFFFFFFF);
      bus(EIQ_MASK_WORD, 1'b0, 32'h0); `CHK(rd, 32'h0000F3FF)
      bus(EIQ_MASK_WORD, 1'b1, 32'h0);
      bus(EIQ_MASK_WORD, 1'b0, 32'h0); `CHK(rd, 32'h00000000)
      bus(EIQ_REPORT_WORD, 1'b1, 32'h0000FFFF);
      bus(EIQ_REPORT_WORD, 1'b0, 32'h0); `CHK(rd, 32'h00000000)
      bus(12'h100, 1'b1, 32'hFFFFFFFF);
      bus(12'h100, 1'b0, 32'h0); `CHK(rd, 32'h0)
      $display("test regs done");
   endtask : t_regs
   task automatic t_irq;
      int bits[13] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 12, 13, 14, 15};
      logic [15:0] one;
      foreach (bits[i]) begin
         one = 16'h0001 << bits[i];
         @(posedge hclk); err_status_in <= one;
         bus(EIQ_MASK_WORD, 1'b1, {16'h0000, ~one & 16'hF3FF});
         settle(3); `CHK(err_irq, 1'b0)
         bus(EIQ_MASK_WORD, 1'b1, {16'h0000, one});
         settle(3); `CHK(err_irq, 1'b1)
      end
      @(posedge hclk); err_status_in <= 16'h1041;
      bus(EIQ_MASK_WORD, 1'b1, 32'h00001000);
      settle(3); `CHK(err_irq, 1'b1)
      @(posedge hclk); err_status_in <= 16'h0000;
      bus(EIQ_MASK_WORD, 1'b1, 32'h00000100);
      $display("test irq done");
   endtask : t_irq
   // c packs prior error, respond, slow, index bad, end bit zero, crc bad, pending
   task automatic stop_run(input logic [6:0] c, input logic [7:0] exp);
      logic seen;
      seen = 1'b0;
      @(posedge hclk); {prior, c_resp, c_slow, c_idx, c_eb, c_crc, pend} <= c; req <= 1'b1;
      @(posedge hclk); req <= 1'b0;
      for (int n = 0; n < 4; n++) begin @(negedge hclk); if (stop_cmd_issued === 1'b1) seen = 1'b1; end
      `CHK(seen, ~c[6])
      if (!c[6]) begin @(posedge hclk); ebs <= 1'b1; @(posedge hclk); ebs <= 1'b0; end
      settle(30);
      bus(EIQ_REPORT_WORD, 1'b0, 32'h0); `CHK(rd[7:0], exp)
      `CHK(stop_cmd_error, |exp[4:0])
      `CHK(err_irq, |exp[4:0])
   endtask : stop_run
   task automatic t_stop;
      stop_run(7'b1000000, 8'h01);
      stop_run(7'b0100000, 8'h00);
      stop_run(7'b0111000, 8'h10);
      stop_run(7'b0100100, 8'h08);
      stop_run(7'b0100011, 8'h84);
      stop_run(7'b0000001, 8'h82);
      stop_run(7'b0100001, 8'h00);
      $display("test stop done");
   endtask : t_stop
   // reset after a finished run must clear the mask, the report and the irq, error and issue outputs
   task automatic t_reset;
      bus(EIQ_MASK_WORD, 1'b1, 32'h0000F3FF);
      stop_run(7'b1000000, 8'h01);
      @(posedge hclk); hresetn <= 1'b0;
      settle(2); `CHK({err_irq, stop_cmd_error, stop_cmd_issued, hreadyout, hresp}, 5'h02)
      @(posedge hclk); hresetn <= 1'b1;
      bus(EIQ_MASK_WORD, 1'b0, 32'h0); `CHK(rd, 32'h00000000)
      bus(EIQ_REPORT_WORD, 1'b0, 32'h0); `CHK(rd, 32'h00000000)
      $display("test reset done");
   endtask : t_reset
   initial begin
      #2500000;
      n_errors++;
      print_verdict();
   end
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_irq();
      t_stop();
      t_reset();
      print_verdict();
   end
endmodule : tb_top
